// ### src/gpio_port_pkg.sv
// shared constants, types and register map of the gpio port
package gpio_port_pkg;

  localparam int MAX_PINS = 8;
  localparam int ADDR_W   = 12;

  // register map (byte addresses); data window covers 0x000-0x3fc
  localparam logic [11:0] OFS_DIR_MODE   = 12'h400;
  localparam logic [11:0] OFS_IRQ_TYPE   = 12'h404;
  localparam logic [11:0] OFS_PAD_WRITE  = 12'h408;
  localparam logic [11:0] OFS_IRQ_EN_SET = 12'h40c;
  localparam logic [11:0] OFS_IRQ_EN_CLR = 12'h410;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h414;
  localparam logic [11:0] OFS_IRQ_MASKED = 12'h418;
  localparam logic [11:0] OFS_PAD_READ   = 12'h420;

  // data window: address bits above this select the window
  localparam int DATA_WIN_MSB  = 11;
  localparam int DATA_WIN_LSB  = 10;
  localparam int DATA_MASK_LSB = 2;
  localparam int PAD_IDX_LSB   = 2;
  localparam int PAD_IDX_W     = 3;
  localparam int PAD_BLK_LSB   = 5;

  // field positions inside write data of configuration registers
  localparam int SEL_LSB      = 0;
  localparam int MODE_LSB     = 8;
  localparam int MODE_W       = 2;
  localparam int TYPE_LSB     = 8;
  localparam int TYPE_W       = 3;
  localparam int STRENGTH_LSB = 8;
  localparam int PULL_LSB     = 10;
  localparam int OD_BIT       = 12;

  // bit 0 of a write/read for hresp, okay only
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {
    DIR_SW_INPUT      = 2'h0,
    DIR_SW_OUTPUT     = 2'h1,
    DIR_HW_CONTROLLED = 2'h2
  } pin_direction_mode_t;

  typedef enum logic [2:0] {
    IRQ_FALLING_EDGE = 3'h0,
    IRQ_RISING_EDGE  = 3'h1,
    IRQ_BOTH_EDGES   = 3'h2,
    IRQ_LOW_LEVEL    = 3'h3,
    IRQ_HIGH_LEVEL   = 3'h4
  } irq_detect_type_t;

  typedef enum logic [1:0] {
    DRIVE_2MA    = 2'h0,
    DRIVE_4MA    = 2'h1,
    DRIVE_8MA    = 2'h2,
    DRIVE_8MA_SC = 2'h3
  } drive_strength_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_UP   = 2'h1,
    PULL_DOWN = 2'h2
  } pull_t;

  typedef struct packed {
    logic            openDrain;
    pull_t           pull;
    drive_strength_t strength;
  } pad_cfg_t;

  localparam pad_cfg_t PAD_CFG_RESET = '{
    openDrain: 1'b0, pull: PULL_NONE, strength: DRIVE_2MA};

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;

endpackage

// ### src/pin_irq_detect.sv
// one pin: input synchroniser, edge/level detector, latched status
`timescale 1ns/1ns
module pin_irq_detect
  import gpio_port_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire logic                           padIn,
  input  wire gpio_port_pkg::irq_detect_type_t detType,
  input  wire logic                           clrStrobe,
  output logic                                syncVal,
  output logic                                rawStatus
);

  logic syncA_r;
  logic syncB_r;
  logic prev_r;
  logic status_r;
  logic statusNxt;
  logic hit;

  always_comb
  begin
    hit = 1'b0;
    case (detType)
      IRQ_FALLING_EDGE: hit = prev_r & ~syncB_r;
      IRQ_RISING_EDGE:  hit = ~prev_r & syncB_r;
      IRQ_BOTH_EDGES:   hit = prev_r ^ syncB_r;
      IRQ_LOW_LEVEL:    hit = ~syncB_r;
      IRQ_HIGH_LEVEL:   hit = syncB_r;
      default:          hit = 1'b0;
    endcase
    // a new event beats a clear in the same cycle
    statusNxt = hit | (status_r & ~clrStrobe);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA_r  <= 1'b0;
      syncB_r  <= 1'b0;
      prev_r   <= 1'b0;
      status_r <= 1'b0;
    end
    else
    begin
      syncA_r  <= padIn;
      syncB_r  <= syncA_r;
      prev_r   <= syncB_r;
      status_r <= statusNxt;
    end
  end

  assign syncVal   = syncB_r;
  assign rawStatus = status_r;

endmodule

// ### src/gpio_port_masked_irq.sv
// eight-pin gpio port with masked data access and per-pin interrupts
// Function
// - up to eight pins, count is parameter
// - per-pin direction, inputs after reset
// - per-pin level or edge interrupt
// - drive 2/4/8 mA, slew with 8, reset 2
// - pull-up, pull-down or none, reset none
// - open-drain or push-pull, reset push-pull
// - gpio or peripheral use, reset gpio
// - peripheral use without function does nothing
// - select byte bit n means pin n
// - masked read returns selected pins only
// - masked write updates selected pins together
// - data mask decoded from address bits
// - mode input, output or hardware, writable
// - each pin mode readable back
// - each pin detect type readable back
// - raw and masked status readable
// - enables set and cleared per group
// - latched status cleared per group
// - unselected pins read as zero
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module gpio_port_masked_irq
  import gpio_port_pkg::*;
#(
  parameter int                      PIN_COUNT   = MAX_PINS,
  parameter logic [MAX_PINS-1:0]     ALT_PRESENT = 8'hff
)
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic [PIN_COUNT-1:0]        padIn,
  output logic      [PIN_COUNT-1:0]        padOut,
  output logic      [PIN_COUNT-1:0]        padOe,
  output gpio_port_pkg::pad_cfg_t [PIN_COUNT-1:0] padCfg,
  input  wire logic [PIN_COUNT-1:0]        altOut,
  input  wire logic [PIN_COUNT-1:0]        altOe,
  output logic      [PIN_COUNT-1:0]        altIn,
  output logic                             irqReq
);

  localparam int N = PIN_COUNT;

  generate
    if (PIN_COUNT < 1 || PIN_COUNT > MAX_PINS)
    begin : g_bad_count
      $error("pin count must be 1 to 8");
    end
  endgenerate

  // bus state
  bus_state_t              busState_r;
  bus_state_t              busStateNxt;
  logic                    wrPend_r;
  logic                    wrPendNxt;
  logic [ADDR_W-1:0]       addr_r;
  logic [ADDR_W-1:0]       addrNxt;
  logic [31:0]             hrdata_r;
  logic [31:0]             hrdataNxt;
  logic                    hreadyout_r;
  logic                    hreadyoutNxt;
  logic                    accept;

  // port configuration state
  logic [N-1:0]                dataOut_r;
  logic [N-1:0]                dataOutNxt;
  pin_direction_mode_t [N-1:0] dir_r;
  pin_direction_mode_t [N-1:0] dirNxt;
  irq_detect_type_t [N-1:0]    detType_r;
  irq_detect_type_t [N-1:0]    detTypeNxt;
  pad_cfg_t [N-1:0]            padCfg_r;
  pad_cfg_t [N-1:0]            padCfgNxt;
  logic [N-1:0]                irqEn_r;
  logic [N-1:0]                irqEnNxt;
  logic [N-1:0]                clrStrobe;

  // pin side
  logic [N-1:0]  padOut_r;
  logic [N-1:0]  padOutNxt;
  logic [N-1:0]  padOe_r;
  logic [N-1:0]  padOeNxt;
  logic [N-1:0]  syncVal;
  logic [N-1:0]  rawStatus;
  logic          irqReq_r;
  logic          irqReqNxt;

  // ---------------- bus slave ----------------
  assign accept = hsel & htrans[1] & hready;

  always_comb
  begin
    busStateNxt  = busState_r;
    wrPendNxt    = 1'b0;
    addrNxt      = addr_r;
    hreadyoutNxt = hreadyout_r;
    hrdataNxt    = hrdata_r;
    case (busState_r)
      BUS_IDLE:
      begin
        hreadyoutNxt = 1'b1;
        if (accept)
        begin
          addrNxt = haddr[ADDR_W-1:0];
          if (hwrite)
          begin
            wrPendNxt = 1'b1;
          end
          else
          begin
            // one wait state so a prior write is visible to the read
            busStateNxt  = BUS_READ;
            hreadyoutNxt = 1'b0;
          end
        end
      end
      BUS_READ:
      begin
        hrdataNxt    = read_mux(addr_r);
        hreadyoutNxt = 1'b1;
        busStateNxt  = BUS_IDLE;
      end
      default:
      begin
        busStateNxt  = BUS_IDLE;
        hreadyoutNxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busState_r  <= BUS_IDLE;
      wrPend_r    <= 1'b0;
      addr_r      <= '0;
      hrdata_r    <= '0;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      busState_r  <= busStateNxt;
      wrPend_r    <= wrPendNxt;
      addr_r      <= addrNxt;
      hrdata_r    <= hrdataNxt;
      hreadyout_r <= hreadyoutNxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = HRESP_OKAY[0];

  // ---------------- read multiplexer ----------------
  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [31:0]          r;
    logic [MAX_PINS-1:0]  sel;
    logic [PAD_IDX_W-1:0] idx;
    r   = '0;
    sel = a[DATA_MASK_LSB +: MAX_PINS];
    idx = a[PAD_IDX_LSB +: PAD_IDX_W];
    if (a[DATA_WIN_MSB:DATA_WIN_LSB] == '0)
    begin
      // masked data read; unselected pins give zero
      r[N-1:0] = syncVal & sel[N-1:0];
    end
    else if (a[ADDR_W-1:PAD_BLK_LSB] == OFS_PAD_READ[ADDR_W-1:PAD_BLK_LSB])
    begin
      if (32'(idx) < N)
      begin
        r[STRENGTH_LSB +: 2] = padCfg_r[idx].strength;
        r[PULL_LSB +: 2]     = padCfg_r[idx].pull;
        r[OD_BIT]            = padCfg_r[idx].openDrain;
      end
    end
    else
    begin
      case (a)
        OFS_DIR_MODE:
          for (int i = 0; i < N; i++)
            r[i*MODE_W +: MODE_W] = dir_r[i];
        OFS_IRQ_TYPE:
          for (int i = 0; i < N; i++)
            r[i*TYPE_W +: TYPE_W] = detType_r[i];
        OFS_IRQ_EN_SET, OFS_IRQ_EN_CLR:
          r[N-1:0] = irqEn_r;
        OFS_IRQ_CLEAR:
          r[N-1:0] = rawStatus;
        OFS_IRQ_MASKED:
          r[N-1:0] = rawStatus & irqEn_r;
        default:
          r = '0;
      endcase
    end
    return r;
  endfunction

  // ---------------- register writes ----------------
  always_comb
  begin
    logic [N-1:0]        sel;
    logic [MAX_PINS-1:0] addrSel;
    dataOutNxt = dataOut_r;
    dirNxt     = dir_r;
    detTypeNxt = detType_r;
    padCfgNxt  = padCfg_r;
    irqEnNxt   = irqEn_r;
    clrStrobe  = '0;
    sel        = hwdata[SEL_LSB +: N];
    addrSel    = addr_r[DATA_MASK_LSB +: MAX_PINS];
    if (wrPend_r)
    begin
      if (addr_r[DATA_WIN_MSB:DATA_WIN_LSB] == '0)
      begin
        // all selected pins change on the same edge
        dataOutNxt = (hwdata[N-1:0] & addrSel[N-1:0])
                   | (dataOut_r & ~addrSel[N-1:0]);
      end
      else
      begin
        case (addr_r)
          OFS_DIR_MODE:
            for (int i = 0; i < N; i++)
              if (sel[i] && hwdata[MODE_LSB +: MODE_W] != 2'h3)
                // hardware mode allowed on any pin, no fault
                dirNxt[i] = pin_direction_mode_t'(
                  hwdata[MODE_LSB +: MODE_W]);
          OFS_IRQ_TYPE:
            for (int i = 0; i < N; i++)
              if (sel[i] && hwdata[TYPE_LSB +: TYPE_W] <= IRQ_HIGH_LEVEL)
                detTypeNxt[i] = irq_detect_type_t'(
                  hwdata[TYPE_LSB +: TYPE_W]);
          OFS_PAD_WRITE:
            for (int i = 0; i < N; i++)
              if (sel[i])
              begin
                padCfgNxt[i].strength = drive_strength_t'(
                  hwdata[STRENGTH_LSB +: 2]);
                padCfgNxt[i].pull = (hwdata[PULL_LSB +: 2] == 2'h3) ?
                  PULL_NONE : pull_t'(hwdata[PULL_LSB +: 2]);
                padCfgNxt[i].openDrain = hwdata[OD_BIT];
              end
          OFS_IRQ_EN_SET:
            irqEnNxt = irqEn_r | sel;
          OFS_IRQ_EN_CLR:
            irqEnNxt = irqEn_r & ~sel;
          OFS_IRQ_CLEAR:
            clrStrobe = sel;
          default:
            clrStrobe = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataOut_r <= '0;
      dir_r     <= '{default: DIR_SW_INPUT};
      detType_r <= '{default: IRQ_FALLING_EDGE};
      padCfg_r  <= {N{PAD_CFG_RESET}};
      irqEn_r   <= '0;
    end
    else
    begin
      dataOut_r <= dataOutNxt;
      dir_r     <= dirNxt;
      detType_r <= detTypeNxt;
      padCfg_r  <= padCfgNxt;
      irqEn_r   <= irqEnNxt;
    end
  end

  // ---------------- per-pin logic ----------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      pin_irq_detect u_det (
        .clock     (clock),
        .rst_b     (rst_b),
        .padIn     (padIn[g]),
        .detType   (detType_r[g]),
        .clrStrobe (clrStrobe[g]),
        .syncVal   (syncVal[g]),
        .rawStatus (rawStatus[g])
      );

      always_comb
      begin
        logic drv;
        logic en;
        drv = 1'b0;
        en  = 1'b0;
        case (dir_r[g])
          DIR_SW_OUTPUT:
          begin
            drv = dataOut_r[g];
            en  = 1'b1;
          end
          DIR_HW_CONTROLLED:
          begin
            // a pin with no peripheral just floats
            drv = ALT_PRESENT[g] & altOut[g];
            en  = ALT_PRESENT[g] & altOe[g];
          end
          default:
          begin
            drv = 1'b0;
            en  = 1'b0;
          end
        endcase
        // open drain only pulls low
        if (padCfg_r[g].openDrain)
        begin
          padOeNxt[g]  = en & ~drv;
          padOutNxt[g] = 1'b0;
        end
        else
        begin
          padOeNxt[g]  = en;
          padOutNxt[g] = drv;
        end
      end
    end
  endgenerate

  assign irqReqNxt = |(rawStatus & irqEn_r);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      padOut_r <= '0;
      padOe_r  <= '0;
      irqReq_r <= 1'b0;
    end
    else
    begin
      padOut_r <= padOutNxt;
      padOe_r  <= padOeNxt;
      irqReq_r <= irqReqNxt;
    end
  end

  assign padOut = padOut_r;
  assign padOe  = padOe_r;
  assign padCfg = padCfg_r;
  assign altIn  = syncVal;
  assign irqReq = irqReq_r;

endmodule

// ### tb/gpio_port_masked_irq_monitor.sv
// concurrent checks on the gpio port's bus, pad and interrupt ports
`timescale 1ns/1ns
module gpio_port_masked_irq_monitor
  import gpio_port_pkg::*;
#(
  parameter int PIN_COUNT = MAX_PINS
)
(
  input wire logic                             clock,
  input wire logic                             rst_b,
  input wire logic                             hsel,
  input wire logic [31:0]                      haddr,
  input wire logic [1:0]                       htrans,
  input wire logic                             hwrite,
  input wire logic [31:0]                      hwdata,
  input wire logic                             hready,
  input wire logic [31:0]                      hrdata,
  input wire logic                             hreadyout,
  input wire logic                             hresp,
  input wire logic [PIN_COUNT-1:0]             padOut,
  input wire logic [PIN_COUNT-1:0]             padOe,
  input wire gpio_port_pkg::pad_cfg_t [PIN_COUNT-1:0] padCfg,
  input wire logic                             irqReq
);
  logic        take;
  logic        wrDp_r;
  logic        rdDp_r;
  logic        dataWr_r;
  logic        clrAll_r;
  logic [11:0] adr_r;
  logic [7:0]  wMask_r;

  assign take = hsel && htrans[1] && hready;

  // tracks data phases and the address mask bits of the last write to any address
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrDp_r   <= 1'b0;
      rdDp_r   <= 1'b0;
      dataWr_r <= 1'b0;
      clrAll_r <= 1'b0;
      adr_r    <= 12'h000;
      wMask_r  <= 8'h00;
    end
    else
    begin
      if (hready)
      begin
        wrDp_r <= take && hwrite;
        rdDp_r <= take && !hwrite;
        adr_r  <= haddr[11:0];
      end
      if (wrDp_r)
        wMask_r <= adr_r[9:2];
      dataWr_r <= wrDp_r && hready && adr_r[11:10] == 2'b00;
      clrAll_r <= wrDp_r && hready && adr_r == OFS_IRQ_EN_CLR
                  && hwdata[7:0] == 8'hff;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  chk_read_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase is not one wait state");
  chk_write_fast:
    assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_rdata_masked:
    assert property (rdDp_r && hreadyout && adr_r[11:10] == 2'b00
      |-> (hrdata & ~{24'h0, adr_r[9:2]}) == 32'h0)
    else $error("masked read shows unselected pins");
  chk_pins_hold:
    assert property (dataWr_r |=>
      ((padOut ^ $past(padOut, 2)) & ~wMask_r[PIN_COUNT-1:0]) == '0)
    else $error("masked write moved an unselected pin");
  chk_irq_masked_off:
    assert property (clrAll_r |=> !irqReq [*2])
    else $error("interrupt line high with all enables clear");
  chk_reset_input:
    assert property ($rose(rst_b) |-> padOe == '0 && !irqReq)
    else $error("pins driven or irq raised after reset");
  chk_pad_reset:
    assert property ($rose(rst_b) |-> padCfg == {PIN_COUNT{PAD_CFG_RESET}})
    else $error("pad settings not at reset values");
  chk_okay_resp:
    assert property (hresp == 1'b0)
    else $error("bus response not okay");
endmodule

bind gpio_port_masked_irq gpio_port_masked_irq_monitor #(
  .PIN_COUNT(PIN_COUNT)
) mon (
  .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .padOut(padOut), .padOe(padOe), .padCfg(padCfg), .irqReq(irqReq)
);

// ### tb/pin_partner.sv
// pin level and peripheral model on the far side of the gpio port
`timescale 1ns/1ns
module pin_partner
  import gpio_port_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic [7:0]               padOut,
  input  wire logic [7:0]               padOe,
  input  wire gpio_port_pkg::pad_cfg_t [7:0] padCfg,
  input  wire logic [7:0]               extVal,
  input  wire logic [7:0]               extEn,
  output logic      [7:0]               padIn,
  output logic      [7:0]               altOut,
  output logic      [7:0]               altOe
);
  logic drift_r = 1'b0;

  // an undriven, unpulled pin wanders every cycle
  always @(posedge clock)
    drift_r <= ~drift_r;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (extEn[i])
        padIn[i] = extVal[i];
      else if (padCfg[i].pull == PULL_UP)
        padIn[i] = 1'b1;
      else if (padCfg[i].pull == PULL_DOWN)
        padIn[i] = 1'b0;
      else
        padIn[i] = drift_r ^ i[0];
    end
  end

  // peripheral drives a fixed pattern, output enable set on pins 0, 1, 6 and 7 only
  assign altOut = 8'h4c;
  assign altOe  = 8'hc3;
endmodule

// ### tb/tb_gpio_port_masked_irq.sv
// self-checking bench: bus, masked data, pads and pin interrupts
`timescale 1ns/1ns
module tb_gpio_port_masked_irq;
  import gpio_port_pkg::*;
  logic           clock = 1'b0;
  logic           rst_b = 1'b0;
  logic           hsel = 1'b0;
  logic [31:0]    haddr = '0;
  logic [1:0]     htrans = '0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = '0;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  logic           irqReq;
  logic [7:0]     padIn, padOut, padOe, altOut, altOe, altIn;
  logic [7:0]     extVal = '0;
  logic [7:0]     extEn = 8'hf0;
  logic [31:0]    rdv;
  logic [4:0]     startLvl = 5'b01101;
  pad_cfg_t [7:0] padCfg;
  int             bad_count = 0;
  int             num_checks = 0;

  always #20 clock = ~clock;

  gpio_port_masked_irq #(.PIN_COUNT(8), .ALT_PRESENT(8'h7f)) dut (
    .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padCfg(padCfg), .altOut(altOut), .altOe(altOe), .altIn(altIn),
    .irqReq(irqReq));

  pin_partner partner (
    .clock(clock), .padOut(padOut), .padOe(padOe), .padCfg(padCfg),
    .extVal(extVal), .extEn(extEn), .padIn(padIn), .altOut(altOut),
    .altOe(altOe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rd(OFS_DIR_MODE, 32'h0);
    rd(OFS_PAD_READ + 12'h1c, 32'h0);
    rd(OFS_IRQ_EN_SET, 32'h0);
    // pins 0-3 outputs, 4-7 inputs
    wr(OFS_DIR_MODE, 32'h10f);
    rd(OFS_DIR_MODE, 32'h55);
    wr(12'h024, 32'hff);
    tick(2);
    chk(32'(padOut), 32'h09);
    wr(12'h018, 32'h02);
    tick(2);
    chk(32'(padOut), 32'h0b);
    chk(32'(padOe), 32'h0f);
    @(posedge clock);
    extVal <= 8'ha0;
    tick(3);
    chk(32'(altIn), 32'hab);
    rd(12'h2a8, 32'haa);
    rd(12'h154, 32'h01);
    // pin 3: 8 mA slew, pull-up, open drain
    wr(OFS_PAD_WRITE, 32'h1708);
    tick(3);
    chk(32'(padCfg[3]), 32'h17);
    chk(32'(padOe), 32'h07);
    chk(32'(padOut), 32'h03);
    rd(OFS_PAD_READ + 12'h0c, 32'h1700);
    rd(12'h020, 32'h08);
    wr(12'h020, 32'h00);
    // pins 6-7 to the peripheral, only pin 6 has one; pin 7 left undriven by the port
    extEn <= 8'hb0;
    wr(OFS_DIR_MODE, 32'h2c0);
    tick(2);
    chk(32'(padOe), 32'h4f);
    chk(32'(padOut), 32'h43);
    rd(OFS_DIR_MODE, 32'ha055);
    for (int t = 0; t < 5; t++)
    begin
      @(posedge clock);
      extVal <= {2'b00, {2{startLvl[t]}}, 4'h0};
      tick(4);
      wr(OFS_IRQ_TYPE, 32'h30 | 32'(t << 8));
      rd(OFS_IRQ_TYPE, 32'((t << 12) | (t << 15)));
      // earlier floating pins latched events; start from a clean slate
      wr(OFS_IRQ_CLEAR, 32'hff);
      wr(OFS_IRQ_EN_SET, 32'h30);
      rd(OFS_IRQ_CLEAR, 32'h0);
      extVal <= {2'b00, {2{~startLvl[t]}}, 4'h0};
      tick(6);
      chk(32'(irqReq), 32'h1);
      rd(OFS_IRQ_MASKED, 32'h30);
      if (t < 3)
      begin
        wr(OFS_IRQ_CLEAR, 32'h10);
        rd(OFS_IRQ_CLEAR, 32'h20);
      end
      wr(OFS_IRQ_EN_CLR, 32'hff);
      tick(2);
      chk(32'(irqReq), 32'h0);
    end
    // reserved mode code leaves the pin alone
    wr(OFS_DIR_MODE, 32'h301);
    rd(OFS_DIR_MODE, 32'ha055);
    wr(OFS_DIR_MODE, 32'h001);
    rd(OFS_DIR_MODE, 32'ha054);
    // reserved detect code leaves the types alone
    wr(OFS_IRQ_TYPE, 32'h5ff);
    rd(OFS_IRQ_TYPE, 32'h24000);
    // pin 0: 4 mA, pull code 3 kept as none; pin 1: 8 mA, pull-down
    wr(OFS_PAD_WRITE, 32'h0d01);
    rd(OFS_PAD_READ, 32'h0100);
    wr(OFS_PAD_WRITE, 32'h0a02);
    rd(OFS_PAD_READ + 12'h04, 32'h0a00);
    wr(12'h41c, 32'hff);
    rd(12'h41c, 32'h0);
    test_done();
  end
endmodule
